// ---- hw/dbc_pkg.sv ----
package dbc_pkg;
  localparam int DBC_CNT_W = 4;
  localparam logic [3:0] DBC_CNT_RESET = 4'h0;
  localparam logic [3:0] DBC_CNT_LAST = 4'h9;
  localparam logic [3:0] DBC_CNT_STEP = 4'h1;
  // Carry is high from this count up to the last one
  localparam logic [3:0] DBC_CARRY_FIRST = 4'h5;
endpackage

// ---- hw/dbc_counter.sv ----
`timescale 1ns/1ps
module dbc_counter
  import dbc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic count_clk,
  input wire logic clk_inhibit,
  input wire logic count_reset,
  output logic [3:0] bcd_count_outputs,
  output logic carry_ttl,
  output logic carry_ecl
);

  // Pins are asynchronous to clk_sys; two flops before any use
  logic [1:0] clk_sync_reg;
  logic [1:0] inh_sync_reg;
  logic [1:0] rst_sync_reg;
  logic clk_prev_reg;
  logic inh_prev_reg;
  logic clk_rise;
  logic inh_rise;
  logic advance;
  logic [3:0] count_reg;

  // Counted clock synchroniser
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      clk_sync_reg <= 2'h0;
    else
      clk_sync_reg <= {clk_sync_reg[0], count_clk};
  end

  // Inhibit synchroniser; its rising edge counts too, so it is more than a gate
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      inh_sync_reg <= 2'h0;
    else
      inh_sync_reg <= {inh_sync_reg[0], clk_inhibit};
  end

  // Reset pin synchroniser; trades two cycles of latency for metastability safety
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      rst_sync_reg <= 2'h0;
    else
      rst_sync_reg <= {rst_sync_reg[0], count_reset};
  end

  // Edge history resets to the idle low level of both pins: no false edge after reset
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      clk_prev_reg <= 1'b0;
      inh_prev_reg <= 1'b0;
    end
    else
    begin
      clk_prev_reg <= clk_sync_reg[1];
      inh_prev_reg <= inh_sync_reg[1];
    end
  end

  // Pin phases shorter than one cycle may be missed
  assign clk_rise = clk_sync_reg[1] & ~clk_prev_reg;
  assign inh_rise = inh_sync_reg[1] & ~inh_prev_reg;

  // Either input's rising edge counts while the other is low;
  // both rising in one cycle leaves neither low, so nothing counts
  assign advance = (clk_rise & ~inh_sync_reg[1])
                 | (inh_rise & ~clk_sync_reg[1]);

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      count_reg <= DBC_CNT_RESET;
    else if (rst_sync_reg[1])
      count_reg <= DBC_CNT_RESET;
    else if (advance)
    begin
      if (count_reg >= DBC_CNT_LAST)
        count_reg <= DBC_CNT_RESET;
      else
        count_reg <= count_reg + DBC_CNT_STEP;
    end
  end

  // Count flop drives the pins directly, no extra stage
  assign bcd_count_outputs = count_reg;

  // Carry high for counts 5..9, one cycle behind the count; falls one cycle after the 9-to-0 wrap to clock the next stage
  // Two flops, not one fanned out, so each family's pin has its own driver
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      carry_ttl <= 1'b0;
      carry_ecl <= 1'b0;
    end
    else
    begin
      carry_ttl <= (count_reg >= DBC_CARRY_FIRST);
      carry_ecl <= (count_reg >= DBC_CARRY_FIRST);
    end
  end

  // Checks watch flops and decoded edges of this block, and a_reset_pin also the count_reset pin

  property p_reset_zero;
    @(posedge clk_sys) disable iff (!resetn)
    rst_sync_reg[1] |=> count_reg == DBC_CNT_RESET;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("count not cleared by reset");

  property p_reset_override;
    @(posedge clk_sys) disable iff (!resetn)
    (rst_sync_reg[1] && advance) |=> count_reg == DBC_CNT_RESET;
  endproperty
  a_reset_override: assert property (p_reset_override)
    else $error("edge counted during reset");

  // Pin high for three cycles has cleared the count one cycle later
  property p_reset_pin;
    @(posedge clk_sys) disable iff (!resetn)
    count_reset [*3] |=> count_reg == DBC_CNT_RESET;
  endproperty
  a_reset_pin: assert property (p_reset_pin)
    else $error("high reset pin did not clear count");

  property p_wrap;
    @(posedge clk_sys) disable iff (!resetn)
    (advance && !rst_sync_reg[1] && count_reg == DBC_CNT_LAST)
    |=> count_reg == DBC_CNT_RESET;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("no wrap after nine");

  property p_step;
    @(posedge clk_sys) disable iff (!resetn)
    (advance && !rst_sync_reg[1] && count_reg < DBC_CNT_LAST)
    |=> count_reg == $past(count_reg) + DBC_CNT_STEP;
  endproperty
  a_step: assert property (p_step)
    else $error("count did not step");

  property p_clk_edge;
    @(posedge clk_sys) disable iff (!resetn)
    (clk_rise && !inh_sync_reg[1] && !rst_sync_reg[1] && count_reg < DBC_CNT_LAST)
    |=> count_reg == $past(count_reg) + DBC_CNT_STEP;
  endproperty
  a_clk_edge: assert property (p_clk_edge)
    else $error("clock edge did not count");

  property p_inh_edge;
    @(posedge clk_sys) disable iff (!resetn)
    (inh_rise && !clk_sync_reg[1] && !rst_sync_reg[1] && count_reg < DBC_CNT_LAST)
    |=> count_reg == $past(count_reg) + DBC_CNT_STEP;
  endproperty
  a_inh_edge: assert property (p_inh_edge)
    else $error("inhibit edge did not count");

  property p_both_edges;
    @(posedge clk_sys) disable iff (!resetn)
    (clk_rise && inh_rise && !rst_sync_reg[1]) |=> $stable(count_reg);
  endproperty
  a_both_edges: assert property (p_both_edges)
    else $error("simultaneous edges counted");

  property p_hold;
    @(posedge clk_sys) disable iff (!resetn)
    (!advance && !rst_sync_reg[1]) |=> $stable(count_reg);
  endproperty
  a_hold: assert property (p_hold)
    else $error("count moved without edge");

  property p_clk_blocked;
    @(posedge clk_sys) disable iff (!resetn)
    (clk_rise && inh_sync_reg[1] && !inh_rise && !rst_sync_reg[1]) |=> $stable(count_reg);
  endproperty
  a_clk_blocked: assert property (p_clk_blocked)
    else $error("clock edge counted while inhibited");

  property p_range;
    @(posedge clk_sys) disable iff (!resetn)
    count_reg <= DBC_CNT_LAST;
  endproperty
  a_range: assert property (p_range)
    else $error("count out of BCD range");

  property p_carry_same;
    @(posedge clk_sys) disable iff (!resetn)
    carry_ttl == carry_ecl;
  endproperty
  a_carry_same: assert property (p_carry_same)
    else $error("carries differ");

  property p_carry_track;
    @(posedge clk_sys) disable iff (!resetn)
    carry_ttl == ($past(count_reg) >= DBC_CARRY_FIRST);
  endproperty
  a_carry_track: assert property (p_carry_track)
    else $error("carry does not follow count");

  property p_carry_fall;
    @(posedge clk_sys) disable iff (!resetn)
    (count_reg == DBC_CNT_LAST ##1 count_reg == DBC_CNT_RESET) |=> !carry_ttl;
  endproperty
  a_carry_fall: assert property (p_carry_fall)
    else $error("carry not dropped at wrap");

  c_wrap: cover property (@(posedge clk_sys) disable iff (!resetn)
    count_reg == DBC_CNT_LAST ##1 count_reg == DBC_CNT_RESET);
  c_inh: cover property (@(posedge clk_sys) disable iff (!resetn)
    inh_rise && !clk_sync_reg[1]);
  c_blocked: cover property (@(posedge clk_sys) disable iff (!resetn)
    clk_rise && inh_sync_reg[1]);
  c_rst: cover property (@(posedge clk_sys) disable iff (!resetn)
    rst_sync_reg[1] && count_reg != DBC_CNT_RESET);
endmodule

// ---- test/dbc_reader.sv ----
`timescale 1ns/1ps
module dbc_reader(
  input wire logic clk_sys,
  input wire logic carry_ttl,
  output int decades
);
  logic last = 1'b0;
  initial decades = 0;
  always @(posedge clk_sys)
  begin
    last <= carry_ttl;
    // Next stage steps on the falling carry
    if (last && !carry_ttl) decades <= decades + 1;
  end
endmodule

// ---- test/decade_bcd_counter_tb.sv ----
`timescale 1ns/1ps
module decade_bcd_counter_tb;
  logic clk_sys = 0, resetn = 0, count_clk = 0, clk_inhibit = 0, count_reset = 0;
  logic [3:0] q;
  logic c_ttl, c_ecl;
  int decades, bad_count = 0, checks = 0, cyc = 0;
  dbc_counter uut(.clk_sys(clk_sys), .resetn(resetn), .count_clk(count_clk),
    .clk_inhibit(clk_inhibit), .count_reset(count_reset), .bcd_count_outputs(q),
    .carry_ttl(c_ttl), .carry_ecl(c_ecl));
  dbc_reader rd(.clk_sys(clk_sys), .carry_ttl(c_ttl), .decades(decades));
  initial forever #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      bad_count++;
      end_sim;
    end
  end
  task automatic chk(string n, logic [3:0] e, logic [3:0] s);
    checks++;
    if (e !== s)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // Reader samples only once pins are quiet, outputs lag the pin edge
  task automatic pulse(ref logic p, input int n);
    repeat (n)
    begin
      p = 1;
      tick(3);
      p = 0;
      tick(3);
    end
    tick(3);
  endtask
  task automatic end_sim;
    $display("bad_count %0d checks %0d", bad_count, checks);
    if (bad_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic t_count;
    pulse(count_clk, 7);
    chk("count", 4'h7, q);
    chk("carry_ttl", 4'h1, {3'h0, c_ttl});
    chk("carry_ecl", 4'h1, {3'h0, c_ecl});
  endtask
  task automatic t_wrap;
    pulse(count_clk, 5);
    chk("count", 4'h2, q);
    chk("carry_ttl", 4'h0, {3'h0, c_ttl});
    chk("carry_ecl", 4'h0, {3'h0, c_ecl});
    chk("decades", 4'h1, 4'(decades));
  endtask
  // Raising inhibit while the clock pin is low is itself a counting edge
  task automatic t_inhibit;
    clk_inhibit = 1;
    tick(6);
    chk("count", 4'h3, q);
    pulse(count_clk, 3);
    clk_inhibit = 0;
    tick(6);
    chk("count", 4'h3, q);
    pulse(clk_inhibit, 1);
    chk("count", 4'h4, q);
  endtask
  task automatic t_pin_reset;
    count_reset = 1;
    pulse(count_clk, 2);
    chk("count", 4'h0, q);
    count_reset = 0;
    tick(2);
    pulse(count_clk, 1);
    chk("count", 4'h1, q);
  endtask
  // System reset in mid-run clears count and both carries at once
  task automatic t_sys_reset;
    pulse(count_clk, 5);
    chk("carry_ttl", 4'h1, {3'h0, c_ttl});
    resetn = 0;
    tick(2);
    chk("count", 4'h0, q);
    chk("carry_ttl", 4'h0, {3'h0, c_ttl});
    chk("carry_ecl", 4'h0, {3'h0, c_ecl});
    resetn = 1;
    tick(1);
    pulse(count_clk, 1);
    chk("count", 4'h1, q);
  endtask
  initial
  begin
    tick(12);
    resetn = 1;
    tick(1);
    t_count;
    t_wrap;
    t_inhibit;
    t_pin_reset;
    t_sys_reset;
    end_sim;
  end
endmodule
